// [core/prr_defs.svh]
// Constants for the pattern register readout block
`ifndef PRR_DEFS_SVH
`define PRR_DEFS_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define PRR_OFF_STATUS   8'h00
`define PRR_OFF_LATCFG   8'h04
`define PRR_OFF_RDCNT    8'h08
`define PRR_OFF_PAT0     8'h10
`define PRR_OFF_PAT1     8'h14
`define PRR_OFF_PAT2     8'h18
`define PRR_OFF_PAT3     8'h1C

// ---------------------------------------------------------------
// Status fields
// ---------------------------------------------------------------
`define PRR_ST_EN        0
`define PRR_ST_FMT_LO    4
`define PRR_ST_PAGE_LO   8
`define PRR_ST_PRE       12
`define PRR_ST_BL_LO     16

// ---------------------------------------------------------------
// Latency config fields and reset values
// ---------------------------------------------------------------
`define PRR_LC_CL_LO     0
`define PRR_LC_AL_LO     8
`define PRR_LAT_W        6
`define PRR_CL_RST       6'h0B
`define PRR_AL_RST       6'h00

// ---------------------------------------------------------------
// Pattern reset contents
// ---------------------------------------------------------------
`define PRR_PAT0_RST     32'h55555555
`define PRR_PAT1_RST     32'h00000000
`define PRR_PAT2_RST     32'h00000000
`define PRR_PAT3_RST     32'h00000000

// ---------------------------------------------------------------
// Command bus layout
// ---------------------------------------------------------------
`define PRR_MR_SEL_ZERO  3'h0
`define PRR_MR_SEL_THREE 3'h3
`define PRR_MR_SEL_FOUR  3'h4
`define PRR_A_PAGE_LO    0
`define PRR_A_ORDER      2
`define PRR_A_FMT_LO     11
`define PRR_A_CHOP       12
`define PRR_A_PRE        11
`define PRR_A_W          18

// ---------------------------------------------------------------
// Read formats and burst field codes
// ---------------------------------------------------------------
`define PRR_FMT_SERIAL   2'h0
`define PRR_FMT_PARALLEL 2'h1
`define PRR_FMT_STAGGER  2'h2
`define PRR_BL_FIXED8    2'h0
`define PRR_BL_OTF       2'h1
`define PRR_BL_CHOP4     2'h2

// ---------------------------------------------------------------
// Burst geometry
// ---------------------------------------------------------------
`define PRR_BEAT_LAST8   3'h7
`define PRR_BEAT_LAST4   3'h3
`define PRR_HALF_OFS     3'h4
`define PRR_BYTE_MSB     3'h7
`define PRR_NIBBLE       4
`define PRR_LOCS         4

`endif

// [core/prr_pkg.sv]
// Types for the pattern register readout block
package prr_pkg;
  typedef enum logic {PRR_IDLE, PRR_DATA} prr_state_t;
  typedef logic [1:0] prr_code_t;
endpackage : prr_pkg

// [core/prr_readout.sv]
// Pattern register readout engine with AHB-Lite register access
`timescale 1ns/1ps
`include "prr_defs.svh"

module prr_readout import prr_pkg::*; #(
  parameter int DQ_W   = 8,
  parameter int PIPE_D = 64
) (
  // Bus clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // AHB-Lite slave
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic                  hreadyout,
  output logic                  hresp,
  output logic [31:0]           hrdata,
  // DRAM command pins
  input  wire logic             dram_ck,
  input  wire logic             cs_n,
  input  wire logic             ras_n,
  input  wire logic             cas_n,
  input  wire logic             we_n,
  input  wire logic [1:0]       bg,
  input  wire logic [1:0]       ba,
  input  wire logic [17:0]      addr,
  // Data and strobe pins
  input  wire logic [DQ_W-1:0]  dq_in,
  output logic      [DQ_W-1:0]  dq_out,
  output logic                  dq_oe_n,
  input  wire logic             dqs_in,
  output logic                  dqs_out,
  output logic                  dqs_oe_n
);

  localparam int CMD_W = 8 + `PRR_A_W;

  // ---------------------------------------------------------------
  // Link synchronisers
  // ---------------------------------------------------------------
  logic [2:0]       ck_sync;
  logic [CMD_W-1:0] cmd_s1;
  logic [CMD_W-1:0] cmd_s2;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ck_sync <= 3'h0;
      cmd_s1  <= {CMD_W{1'b1}};
      cmd_s2  <= {CMD_W{1'b1}};
    end else begin
      ck_sync <= {ck_sync[1:0], dram_ck};
      cmd_s1  <= {cs_n, ras_n, cas_n, we_n, bg, ba, addr};
      cmd_s2  <= cmd_s1;
    end
  end

  logic                rise;
  logic                fall;
  logic                c_cs_n;
  logic                c_ras_n;
  logic                c_cas_n;
  logic                c_we_n;
  logic [1:0]          c_bg;
  logic [1:0]          c_ba;
  logic [`PRR_A_W-1:0] c_a;
  logic                is_mrs;
  logic                is_rd;
  logic [2:0]          mr_sel;

  assign rise = ck_sync[1] & ~ck_sync[2];
  assign fall = ~ck_sync[1] & ck_sync[2];
  assign {c_cs_n, c_ras_n, c_cas_n, c_we_n, c_bg, c_ba, c_a} = cmd_s2;
  assign is_mrs = rise & ~c_cs_n & ~c_ras_n & ~c_cas_n & ~c_we_n;
  assign is_rd  = rise & ~c_cs_n & c_ras_n & ~c_cas_n & c_we_n;
  assign mr_sel = {c_bg[0], c_ba};

  // ---------------------------------------------------------------
  // Mode register shadows
  // ---------------------------------------------------------------
  logic      mode_en;
  prr_code_t fmt;
  prr_code_t page;
  prr_code_t bl_mode;
  logic      pre2;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_en <= 1'b0;
      fmt     <= `PRR_FMT_SERIAL;
      page    <= 2'h0;
    end else if (is_mrs && mr_sel == `PRR_MR_SEL_THREE) begin
      mode_en <= c_a[`PRR_A_ORDER];
      fmt     <= c_a[`PRR_A_FMT_LO +: 2];
      page    <= c_a[`PRR_A_PAGE_LO +: 2];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bl_mode <= `PRR_BL_FIXED8;
      pre2    <= 1'b0;
    end else if (is_mrs && mr_sel == `PRR_MR_SEL_ZERO) begin
      bl_mode <= c_a[`PRR_A_PAGE_LO +: 2];
    end else if (is_mrs && mr_sel == `PRR_MR_SEL_FOUR) begin
      pre2    <= c_a[`PRR_A_PRE];
    end
  end

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  logic [31:0]             pat_mem [0:`PRR_LOCS-1];
  logic [`PRR_LAT_W-1:0]   cas_lat;
  logic [`PRR_LAT_W-1:0]   add_lat;
  logic [31:0]             rd_cnt;
  logic                    wr_pend;
  logic [7:0]              wr_addr;
  logic                    acc;
  logic [31:0]             status;

  assign acc       = hsel & hready & htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_comb begin
    status = 32'h0;
    status[`PRR_ST_EN]            = mode_en;
    status[`PRR_ST_FMT_LO +: 2]   = fmt;
    status[`PRR_ST_PAGE_LO +: 2]  = page;
    status[`PRR_ST_PRE]           = pre2;
    status[`PRR_ST_BL_LO +: 2]    = bl_mode;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h0;
    end else begin
      wr_pend <= acc & hwrite;
      wr_addr <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
    end else if (acc && !hwrite) begin
      if (haddr[7:0] == `PRR_OFF_STATUS) begin
        hrdata <= status;
      end else if (haddr[7:0] == `PRR_OFF_LATCFG) begin
        hrdata <= {16'h0, 2'h0, add_lat, 2'h0, cas_lat};
      end else if (haddr[7:0] == `PRR_OFF_RDCNT) begin
        hrdata <= rd_cnt;
      end else if (haddr[7:0] == `PRR_OFF_PAT0) begin
        hrdata <= pat_mem[0];
      end else if (haddr[7:0] == `PRR_OFF_PAT1) begin
        hrdata <= pat_mem[1];
      end else if (haddr[7:0] == `PRR_OFF_PAT2) begin
        hrdata <= pat_mem[2];
      end else if (haddr[7:0] == `PRR_OFF_PAT3) begin
        hrdata <= pat_mem[3];
      end else begin
        hrdata <= 32'h0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cas_lat    <= `PRR_CL_RST;
      add_lat    <= `PRR_AL_RST;
      pat_mem[0] <= `PRR_PAT0_RST;
      pat_mem[1] <= `PRR_PAT1_RST;
      pat_mem[2] <= `PRR_PAT2_RST;
      pat_mem[3] <= `PRR_PAT3_RST;
    end else if (wr_pend) begin
      if (wr_addr == `PRR_OFF_LATCFG) begin
        cas_lat <= hwdata[`PRR_LC_CL_LO +: `PRR_LAT_W];
        add_lat <= hwdata[`PRR_LC_AL_LO +: `PRR_LAT_W];
      end else if (wr_addr == `PRR_OFF_PAT0) begin
        pat_mem[0] <= hwdata;
      end else if (wr_addr == `PRR_OFF_PAT1) begin
        pat_mem[1] <= hwdata;
      end else if (wr_addr == `PRR_OFF_PAT2) begin
        pat_mem[2] <= hwdata;
      end else if (wr_addr == `PRR_OFF_PAT3) begin
        pat_mem[3] <= hwdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // Latency pipeline
  // ---------------------------------------------------------------
  logic [PIPE_D-1:0] p_vld;
  logic [1:0]        p_loc  [0:PIPE_D-1];
  logic              p_half [0:PIPE_D-1];
  logic              p_chop [0:PIPE_D-1];
  logic [6:0]        rl;
  logic              take;
  logic              chop_now;

  assign rl       = {1'b0, add_lat} + {1'b0, cas_lat};
  assign take     = is_rd & mode_en;
  assign chop_now = (bl_mode == `PRR_BL_CHOP4);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      p_vld <= '0;
      for (int i = 0; i < PIPE_D; i++) begin
        p_loc[i]  <= 2'h0;
        p_half[i] <= 1'b0;
        p_chop[i] <= 1'b0;
      end
    end else if (rise) begin
      for (int i = 0; i < PIPE_D; i++) begin
        if (take && int'(rl) == i + 1) begin
          p_vld[i]  <= 1'b1;
          p_loc[i]  <= c_ba;
          p_half[i] <= chop_now & c_a[`PRR_A_ORDER];
          p_chop[i] <= chop_now;
        end else if (i < PIPE_D - 1) begin
          p_vld[i]  <= p_vld[i+1];
          p_loc[i]  <= p_loc[i+1];
          p_half[i] <= p_half[i+1];
          p_chop[i] <= p_chop[i+1];
        end else begin
          p_vld[i]  <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_cnt <= 32'h0;
    end else if (take) begin
      rd_cnt <= rd_cnt + 32'h1;
    end
  end

  // ---------------------------------------------------------------
  // Burst engine
  // ---------------------------------------------------------------
  prr_state_t st;
  logic [2:0] beat;
  logic [1:0] b_loc;
  logic       b_half;
  logic       b_chop;
  logic [2:0] last;

  assign last = b_chop ? `PRR_BEAT_LAST4 : `PRR_BEAT_LAST8;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st     <= PRR_IDLE;
      beat   <= 3'h0;
      b_loc  <= 2'h0;
      b_half <= 1'b0;
      b_chop <= 1'b0;
    end else begin
      case (st)
        PRR_IDLE: begin
          if (rise && p_vld[0]) begin
            st     <= PRR_DATA;
            beat   <= 3'h0;
            b_loc  <= p_loc[0];
            b_half <= p_half[0];
            b_chop <= p_chop[0];
          end
        end
        PRR_DATA: begin
          if (rise && p_vld[0]) begin
            beat   <= 3'h0;
            b_loc  <= p_loc[0];
            b_half <= p_half[0];
            b_chop <= p_chop[0];
          end else if ((rise || fall) && beat == last) begin
            st     <= PRR_IDLE;
          end else if (rise || fall) begin
            beat   <= beat + 3'h1;
          end
        end
        default: st <= PRR_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Lane data and strobe
  // ---------------------------------------------------------------
  logic [DQ_W-1:0] next_dq;
  logic [2:0]      ui;
  logic            pre_win;

  assign ui = beat + (b_half ? `PRR_HALF_OFS : 3'h0);

  always_comb begin
    logic [1:0] sl;
    logic [7:0] byt;
    sl      = 2'h0;
    byt     = 8'h0;
    next_dq = '0;
    for (int j = 0; j < DQ_W; j++) begin
      if (fmt == `PRR_FMT_STAGGER) begin
        sl  = b_loc + 2'(j % `PRR_NIBBLE);
        byt = pat_mem[0][8*sl +: 8];
        next_dq[j] = byt[`PRR_BYTE_MSB - ui];
      end else if (fmt == `PRR_FMT_PARALLEL) begin
        byt = pat_mem[page][8*b_loc +: 8];
        next_dq[j] = byt[j % 8];
      end else begin
        byt = pat_mem[page][8*b_loc +: 8];
        next_dq[j] = byt[`PRR_BYTE_MSB - ui];
      end
    end
  end

  assign pre_win = p_vld[0] | (pre2 & p_vld[1]);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dq_out   <= '0;
      dq_oe_n  <= 1'b1;
      dqs_out  <= 1'b0;
      dqs_oe_n <= 1'b1;
    end else begin
      dq_out   <= next_dq;
      dq_oe_n  <= (st != PRR_DATA);
      dqs_out  <= (st == PRR_DATA) & ~beat[0];
      dqs_oe_n <= (st != PRR_DATA) & ~pre_win;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  stagger_lane_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (st == PRR_DATA && fmt == `PRR_FMT_STAGGER) |=>
      dq_out[1] == $past(pat_mem[0][8*2'(b_loc + 2'h1) + 7 - ui]))
    else $error("staggered lane one carries wrong location");

  nibble_repeat_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (!dq_oe_n && $past(fmt) == `PRR_FMT_STAGGER && DQ_W >= 8) |->
      dq_out[7:4] == dq_out[3:0])
    else $error("upper nibble differs from lower nibble");

  seamless_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (rise && p_vld[0]) |=> st == PRR_DATA ##1 !dq_oe_n)
    else $error("burst did not start on its clock");

  latency_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (take && rl != 7'h0 && rl <= 7'(PIPE_D)) |=> p_vld[$past(rl) - 1])
    else $error("read not queued at read latency");

  strobe_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !dq_oe_n |-> !dqs_oe_n)
    else $error("data driven without strobe");

  chop_len_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (st == PRR_DATA && b_chop) |-> beat <= `PRR_BEAT_LAST4)
    else $error("chopped burst ran past four beats");

  no_core_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (is_rd && !mode_en) |=> rd_cnt == $past(rd_cnt))
    else $error("read served while readout disabled");

  mode_set_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (is_mrs && mr_sel == `PRR_MR_SEL_THREE) |=>
      mode_en == $past(c_a[`PRR_A_ORDER]) && fmt == $past(c_a[12:11]))
    else $error("mode register three not captured");

  page_set_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (is_mrs && mr_sel == `PRR_MR_SEL_THREE) |=> page == $past(c_a[1:0]))
    else $error("page field not captured");

endmodule : prr_readout

// [verif/prr_ctrl_model.sv]
// Controller model: link clock and command pins
`timescale 1ns/1ps
module prr_ctrl_model #(
  parameter int MOD_CK   = 8,
  parameter int RP_CK    = 4,
  parameter int RECOV_CK = 4
) (
  // Link clock
  output logic        dram_ck,
  // Command pins
  output logic        cs_n,
  output logic        ras_n,
  output logic        cas_n,
  output logic        we_n,
  output logic [1:0]  bg,
  output logic [1:0]  ba,
  output logic [17:0] addr
);
  int hp;
  int last_hp;

  // ------
  // Free-running clock, phase unrelated to hclk
  // ------
  initial begin
    hp = 0;
    dram_ck = 1'b0;
    {cs_n, ras_n, cas_n, we_n} = 4'hF;
    bg = 2'h0;
    ba = 2'h0;
    addr = 18'h00000;
    #37;
    forever begin
      #80;
      hp = hp + 1;
      dram_ck = ~dram_ck;
    end
  end

  // ------
  // Commands
  // ------
  task automatic idle(input int n);
    repeat (n) @(negedge dram_ck);
  endtask : idle

  task automatic cmd(input logic [3:0] c, input logic [1:0] g, b,
                     input logic [17:0] a);
    @(negedge dram_ck);
    {cs_n, ras_n, cas_n, we_n} <= c;
    bg   <= g;
    ba   <= b;
    addr <= a;
    @(posedge dram_ck);
    last_hp = hp;
    @(negedge dram_ck);
    {cs_n, ras_n, cas_n, we_n} <= {1'b1, ~c[2:0]};
    bg   <= ~g;
    ba   <= ~b;
    addr <= ~a;
  endtask : cmd

  task automatic mrs(input logic [2:0] sel, input logic [17:0] a);
    cmd(4'h0, {1'b0, sel[2]}, sel[1:0], a);
    idle(MOD_CK);
  endtask : mrs

  // Loop locked from start; close all banks first
  task automatic prech();
    cmd(4'h2, 2'h0, 2'h0, 18'h00400);
    idle(RP_CK);
  endtask : prech

  task automatic rd(input logic [1:0] b, input logic a2, chop,
                    input logic [17:0] j, input int gap);
    cmd(4'h5, j[1:0], b, (j & 18'h3EFF8) | {5'h0, chop, 9'h0, a2, 2'h0});
    idle(gap);
  endtask : rd

  task automatic leave();
    idle(RECOV_CK);
    mrs(3'h3, 18'h00000);
  endtask : leave
endmodule : prr_ctrl_model

// [verif/pattern_register_readout_tb_top.sv]
// Testbench top for the pattern register readout block
`timescale 1ns/1ps
`include "prr_defs.svh"
module pattern_register_readout_tb_top;
  logic        hclk = 1'b0;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        dram_ck;
  logic        cs_n;
  logic        ras_n;
  logic        cas_n;
  logic        we_n;
  logic [1:0]  bg;
  logic [1:0]  ba;
  logic [17:0] addr;
  logic [7:0]  dq_out;
  logic        dq_oe_n;
  logic        dqs_out;
  logic        dqs_oe_n;
  int          seed = 32'he99d;
  int          miscompares;
  int          checks_done;
  int          cyc;
  int          rl = 11;
  int          pre = 1;
  int          nb = 8;
  int          served;
  logic [1:0]  bfield = 2'h0;
  logic [31:0] rdv;
  logic [31:0] rnd;
  logic [31:0] pat [4];
  logic [8:0]  dqv [int];
  logic [1:0]  dqsv [int];
  int          hq [$];
  int          bq [$];
  int          oq [$];
  logic [7:0]  offs [8] = '{`PRR_OFF_STATUS, `PRR_OFF_LATCFG, `PRR_OFF_RDCNT,
    `PRR_OFF_PAT0, `PRR_OFF_PAT1, `PRR_OFF_PAT2, `PRR_OFF_PAT3, 8'h20};
  logic [31:0] rstv [8] = '{32'h0, {18'h0, `PRR_AL_RST, 2'h0, `PRR_CL_RST},
    32'h0, `PRR_PAT0_RST, `PRR_PAT1_RST, `PRR_PAT2_RST, `PRR_PAT3_RST, 32'h0};

  always #5 hclk = ~hclk;

  prr_readout #(.DQ_W(8), .PIPE_D(64)) u_prr_readout (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .dram_ck(dram_ck), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .bg(bg), .ba(ba), .addr(addr),
    .dq_in(8'h00), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .dqs_in(1'b0),
    .dqs_out(dqs_out), .dqs_oe_n(dqs_oe_n));

  prr_ctrl_model u_prr_ctrl_model (
    .dram_ck(dram_ck), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .bg(bg), .ba(ba), .addr(addr));

  // ------
  // Capture pins mid half period, timeout
  // ------
  always @(dram_ck) begin : cap_p
    int h;
    h = u_prr_ctrl_model.hp;
    repeat (6) @(posedge hclk);
    dqv[h]  = {dq_oe_n, dq_out};
    dqsv[h] = {dqs_oe_n, dqs_out};
  end

  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      miscompares++;
      final_report();
    end
  end

  // ------
  // Tasks and expectations
  // ------
  task automatic check(input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : final_report

  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : ahb

  function automatic logic [7:0] exp_beat(input logic [1:0] f, pg, b,
                                          input int u);
    logic [7:0] v;
    for (int j = 0; j < 8; j++)
      v[j] = (f == `PRR_FMT_STAGGER) ? pat[0][8 * ((b + j) % 4) + 7 - u]
           : (f == `PRR_FMT_PARALLEL) ? pat[pg][8 * b + j]
                                     : pat[pg][8 * b + 7 - u];
    return v;
  endfunction : exp_beat

  task automatic mr3(input logic [1:0] f, pg, input logic en);
    u_prr_ctrl_model.mrs(`PRR_MR_SEL_THREE, {5'h0, f, 8'h0, en, pg});
    ahb(1'b0, `PRR_OFF_STATUS, 32'h0, rdv);
    check(rdv, {14'h0, bfield, 3'h0, pre == 2, 2'h0, pg, 2'h0, f, 3'h0, en});
  endtask : mr3

  task automatic rd(input logic [1:0] b, input logic a2);
    logic [31:0] j;
    j = $random(seed);
    u_prr_ctrl_model.rd(b, a2, bfield == `PRR_BL_OTF, j[17:0], 2);
    hq.push_back(u_prr_ctrl_model.last_hp);
    bq.push_back(b);
    oq.push_back(a2 ? 4 : 0);
  endtask : rd

  task automatic drain(input logic [1:0] f, pg, input logic en);
    int h;
    int u;
    h = hq[$] + 2 * rl + 12;
    while (u_prr_ctrl_model.hp < h) @(posedge hclk);
    repeat (8) @(posedge hclk);
    foreach (hq[i]) begin
      h = hq[i] + 2 * rl;
      for (u = 1; u <= 2 * pre && en && i == 0; u++)
        check(dqsv[h-u], 2'h0);
      for (u = 0; u < nb && en; u++) begin
        check(dqv[h+u], {1'b0, exp_beat(f, pg, bq[i], u + oq[i])});
        check(dqsv[h+u], {1'b0, ~u[0]});
      end
      if (en && nb == 4) check(dqv[h+4][8], 1'b1);
      if (!en) check(dqv[h][8], 1'b1);
      if (en) served++;
    end
    if (en) check(dqv[h+8][8], 1'b1);
    hq.delete();
    bq.delete();
    oq.delete();
  endtask : drain

  // ------
  // Main sequence
  // ------
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      ahb(1'b0, offs[i], 32'h0, rdv);
      check(rdv, rstv[i]);
    end
    for (int i = 0; i < 8; i += 1 + (i == 0) * 1 + (i == 2) * 4) begin
      ahb(1'b1, offs[i], 32'hFFFFFFFF, rdv);
      ahb(1'b0, offs[i], 32'h0, rdv);
      check(rdv, rstv[i]);
    end
    ahb(1'b1, `PRR_OFF_LATCFG, 32'h00000105, rdv);
    ahb(1'b0, `PRR_OFF_LATCFG, 32'h0, rdv);
    check(rdv, 32'h00000105);
    rl = 6;
    for (int i = 0; i < 4; i++) begin
      pat[i] = $random(seed);
      ahb(1'b1, offs[3+i], pat[i], rdv);
      ahb(1'b0, offs[3+i], 32'h0, rdv);
      check(rdv, pat[i]);
    end
    check({hreadyout, hresp}, 2'h2);
    $display("test registers done");
    rd(2'h1, 1'b0);
    drain(`PRR_FMT_SERIAL, 2'h0, 1'b0);
    u_prr_ctrl_model.prech();
    for (int p = 0; p < 4; p++) begin
      mr3(`PRR_FMT_SERIAL, p[1:0], 1'b1);
      rnd = $random(seed);
      rd(rnd[1:0], 1'b0);
      drain(`PRR_FMT_SERIAL, p[1:0], 1'b1);
    end
    mr3(`PRR_FMT_PARALLEL, 2'h0, 1'b1);
    rd(2'h2, 1'b0);
    drain(`PRR_FMT_PARALLEL, 2'h0, 1'b1);
    mr3(`PRR_FMT_STAGGER, 2'h0, 1'b1);
    for (int i = 0; i < 8; i++) rd(i[1:0], 1'b0);
    drain(`PRR_FMT_STAGGER, 2'h0, 1'b1);
    $display("test serial and staggered done");
    bfield = `PRR_BL_CHOP4;
    nb = 4;
    u_prr_ctrl_model.mrs(`PRR_MR_SEL_ZERO, {16'h0, bfield});
    mr3(`PRR_FMT_STAGGER, 2'h0, 1'b1);
    rd(2'h2, 1'b0);
    rd(2'h3, 1'b1);
    drain(`PRR_FMT_STAGGER, 2'h0, 1'b1);
    bfield = `PRR_BL_OTF;
    nb = 8;
    u_prr_ctrl_model.mrs(`PRR_MR_SEL_ZERO, {16'h0, bfield});
    rd(2'h1, 1'b0);
    drain(`PRR_FMT_STAGGER, 2'h0, 1'b1);
    bfield = `PRR_BL_FIXED8;
    u_prr_ctrl_model.mrs(`PRR_MR_SEL_ZERO, {16'h0, bfield});
    $display("test burst kinds done");
    pre = 2;
    u_prr_ctrl_model.mrs(`PRR_MR_SEL_FOUR, 18'h00800);
    mr3(`PRR_FMT_SERIAL, 2'h3, 1'b1);
    rd(2'h2, 1'b0);
    drain(`PRR_FMT_SERIAL, 2'h3, 1'b1);
    u_prr_ctrl_model.leave();
    ahb(1'b0, `PRR_OFF_STATUS, 32'h0, rdv);
    check(rdv, {19'h0, 1'b1, 12'h0});
    rd(2'h0, 1'b0);
    drain(`PRR_FMT_SERIAL, 2'h0, 1'b0);
    ahb(1'b0, `PRR_OFF_RDCNT, 32'h0, rdv);
    check(rdv, served);
    $display("test preamble and exit done");
    final_report();
  end
endmodule : pattern_register_readout_tb_top
